// *** hdl/smc_pkg.sv ***
// constants shared by the misc system control register bank
// assumes a 16-bit register view placed in the low half of a 32-bit bus word
package smc_pkg;
  // byte addresses of the three registers
  localparam logic [3:0] LOCK_OFS = 4'h0;
  localparam logic [3:0] RAMSZ_OFS = 4'h4;
  localparam logic [3:0] FLASH_OFS = 4'h8;
  // key value that lifts the write lock, and key after reset
  localparam logic [15:0] UNLOCK_KEY = 16'h0096;
  localparam logic [15:0] KEY_RST = 16'h0000;
  // ram size field
  localparam logic [2:0] RAMSZ_RST = 3'h3;
  localparam int RAMSZ_LSB = 0;
  localparam int RAMSZ_RSV_BIT = 8;
  localparam logic [4:0] RAMSZ_FIXED = 5'h06;
  localparam int RAMSZ_FIXED_LSB = 3;
  // flash read timing field
  localparam logic [1:0] RDCYC_RST = 2'h1;
  localparam int RDCYC_LSB = 0;
  localparam int FLASH_RDY_BIT = 7;
  // ram size codes
  typedef enum logic [2:0] {
    SMC_RAM_512B = 3'h0,
    SMC_RAM_1KB = 3'h1,
    SMC_RAM_2KB = 3'h2,
    SMC_RAM_4KB = 3'h3,
    SMC_RAM_8KB = 3'h4
  } smc_ram_size_t;
endpackage : smc_pkg

// *** hdl/smc_cfg_if.sv ***
// carries the flash access configuration from the register bank to the
// flash read sequencer; both ends run on sys_clk
`timescale 1ns/1ns
interface smc_cfg_if;
  logic [1:0] read_cycle_count;
  logic rd_req;
  logic rd_done;
  logic rd_busy;
  modport regs (output read_cycle_count, output rd_req, input rd_done,
    input rd_busy);
  modport seq (input read_cycle_count, input rd_req, output rd_done,
    output rd_busy);
endinterface : smc_cfg_if

// *** hdl/smc_flash_seq.sv ***
// flash read sequencer: times each read access by the programmed count
// assumes rd_req is a one-cycle pulse on sys_clk, given only while idle
`timescale 1ns/1ns
module smc_flash_seq (
  input wire logic sys_clk,
  input wire logic rst,
  smc_cfg_if.seq cfg
);
  typedef enum logic [0:0] {
    SMC_SEQ_IDLE = 1'b0,
    SMC_SEQ_BUSY = 1'b1
  } smc_seq_state_t;

  smc_seq_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic done_q, done_d;

  assign cfg.rd_done = done_q;
  assign cfg.rd_busy = (state_q == SMC_SEQ_BUSY);

  // access of code+1 cycles; done pulses code+1 cycles after the request
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    unique case (state_q)
      SMC_SEQ_IDLE: begin
        if (cfg.rd_req) begin
          if (cfg.read_cycle_count == 2'h0) begin
            done_d = 1'b1;
          end else begin
            cnt_d = cfg.read_cycle_count;
            state_d = SMC_SEQ_BUSY;
          end
        end
      end
      SMC_SEQ_BUSY: begin
        if (cnt_q == 2'h1) begin
          done_d = 1'b1;
          state_d = SMC_SEQ_IDLE;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= SMC_SEQ_IDLE;
      cnt_q <= 2'h0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end
endmodule : smc_flash_seq

// *** hdl/smc_regs.sv ***
// misc system control register bank with key-based write lock, ram size
// setting and flash read timing, reached over an avalon-mm slave
// assumes one clock sys_clk, asynchronous active-high rst, a master that
// holds each request until waitrequest is seen low
//
// Operation
// - key 0x0096 lifts the write lock
// - any other key keeps lock; reset locks
// - locked writes to lockable bits ignored
// - unlock persists until non-unlock key written
// - lockable 3-bit ram size, reset 4KB
// - read-only flash ready flag at bit 7
// - flash reported ready in normal operation
// - 2-bit read cycle count sets access length
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
module smc_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic flash_hold_pin,
  input wire logic flash_rd_req,
  output logic flash_rd_done,
  output logic [2:0] ram_size_select,
  output logic [1:0] read_cycle_count,
  output logic write_unlocked
);
  smc_cfg_if cfg ();

  // request, bus and register state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] key_q, key_d;
  logic unlock_q, unlock_d;
  logic [2:0] ramsz_q, ramsz_d;
  logic ramsz_rsv_q, ramsz_rsv_d;
  logic [1:0] rdcyc_q, rdcyc_d;
  logic hold_s1_q, hold_s2_q;
  logic ready_q, ready_d;
  logic req;
  logic wr_go;
  logic [15:0] wmask;

  // merge write data into a 16-bit register under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [15:0] wd, input logic [15:0] m);
    merge16 = (old & ~m) | (wd & m);
  endfunction : merge16

  // read view of each register
  function automatic logic [15:0] view(input logic [3:0] a,
    input logic [15:0] key, input logic [2:0] rs, input logic rsv,
    input logic rdy, input logic [1:0] rc);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      smc_pkg::LOCK_OFS: v = key;
      smc_pkg::RAMSZ_OFS: begin
        v[smc_pkg::RAMSZ_LSB +: 3] = rs;
        v[smc_pkg::RAMSZ_FIXED_LSB +: 5] = smc_pkg::RAMSZ_FIXED;
        v[smc_pkg::RAMSZ_RSV_BIT] = rsv;
      end
      smc_pkg::FLASH_OFS: begin
        v[smc_pkg::FLASH_RDY_BIT] = rdy;
        v[smc_pkg::RDCYC_LSB +: 2] = rc;
      end
      default: v = 16'h0000;
    endcase
    view = v;
  endfunction : view

  assign req = avs_read | avs_write;
  assign wr_go = avs_write & ~wait_q;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // one wait cycle per request; write commits on the cycle wait is low
  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (req & wait_q) begin
      wait_d = 1'b0;
      rdata_d = {16'h0000, view(avs_address, key_q, ramsz_q, ramsz_rsv_q,
        ready_q, rdcyc_q)};
    end
  end

  // key register and lock state
  always_comb begin
    key_d = key_q;
    if (wr_go && avs_address == smc_pkg::LOCK_OFS) begin
      key_d = merge16(key_q, avs_writedata[15:0], wmask);
    end
    unlock_d = (key_d == smc_pkg::UNLOCK_KEY);
  end

  // lockable fields change only while unlocked
  always_comb begin
    ramsz_d = ramsz_q;
    ramsz_rsv_d = ramsz_rsv_q;
    rdcyc_d = rdcyc_q;
    if (wr_go && unlock_q) begin
      if (avs_address == smc_pkg::RAMSZ_OFS) begin
        if (avs_byteenable[0]) begin
          ramsz_d = avs_writedata[smc_pkg::RAMSZ_LSB +: 3];
        end
        if (avs_byteenable[1]) begin
          ramsz_rsv_d = avs_writedata[smc_pkg::RAMSZ_RSV_BIT];
        end
      end
      if (avs_address == smc_pkg::FLASH_OFS && avs_byteenable[0]) begin
        rdcyc_d = avs_writedata[smc_pkg::RDCYC_LSB +: 2];
      end
    end
  end

  // flash ready unless the hold pin asks to block access
  always_comb begin
    ready_d = ~hold_s2_q;
  end

  // register all state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      key_q <= smc_pkg::KEY_RST;
      unlock_q <= 1'b0;
      ramsz_q <= smc_pkg::RAMSZ_RST;
      ramsz_rsv_q <= 1'b0;
      rdcyc_q <= smc_pkg::RDCYC_RST;
      hold_s1_q <= 1'b0;
      hold_s2_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      key_q <= key_d;
      unlock_q <= unlock_d;
      ramsz_q <= ramsz_d;
      ramsz_rsv_q <= ramsz_rsv_d;
      rdcyc_q <= rdcyc_d;
      hold_s1_q <= flash_hold_pin;
      hold_s2_q <= hold_s1_q;
      ready_q <= ready_d;
    end
  end

  // flash read sequencer paced by the read cycle field
  assign cfg.read_cycle_count = rdcyc_q;
  assign cfg.rd_req = flash_rd_req & ~cfg.rd_busy; // drop requests while busy

  smc_flash_seq u_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg)
  );

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign flash_rd_done = cfg.rd_done;
  assign ram_size_select = ramsz_q;
  assign read_cycle_count = rdcyc_q;
  assign write_unlocked = unlock_q;
endmodule : smc_regs

// *** test/smc_regs_asserts.sv ***
// checker for the misc system control register bank
// assumes binding to smc_regs on sys_clk with async active-high rst
`timescale 1ns/1ns
module smc_regs_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic flash_hold_pin,
  input wire logic [2:0] ram_size_select,
  input wire logic [1:0] read_cycle_count,
  input wire logic write_unlocked
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // bus cycles at their completing edge
  wire wr_go = avs_write && !avs_waitrequest;
  wire rd_go = avs_read && !avs_waitrequest;
  chk_key_unlock:
  assert property ($rose(write_unlocked) |-> $past(wr_go &&
    avs_address == 4'h0 && avs_writedata[15:0] == 16'h0096))
    else $error("unlock without key");
  chk_key_relock:
  assert property ($fell(write_unlocked) |-> $past(wr_go &&
    avs_address == 4'h0)) else $error("relock without key write");
  chk_lock_hold:
  assert property (!write_unlocked |=> $stable(ram_size_select) &&
    $stable(read_cycle_count)) else $error("locked field changed");
  chk_cycle_write:
  assert property (wr_go && write_unlocked && avs_address == 4'h8 |=>
    read_cycle_count == $past(avs_writedata[1:0]))
    else $error("read cycle count not written");
  chk_size_write:
  assert property (wr_go && write_unlocked && avs_address == 4'h4 |=>
    ram_size_select == $past(avs_writedata[2:0]))
    else $error("ram size not written");
  chk_size_read:
  assert property (rd_go && avs_address == 4'h4 |-> avs_readdata ==
    {23'h0, avs_readdata[8], 5'h06, ram_size_select})
    else $error("ram size read format");
  chk_flash_ready:
  assert property ((!flash_hold_pin)[*6] ##0 (rd_go &&
    avs_address == 4'h8) |-> avs_readdata[7]) else $error("not ready");
  chk_flash_busy:
  assert property (flash_hold_pin[*6] ##0 (rd_go &&
    avs_address == 4'h8) |-> !avs_readdata[7]) else $error("not busy");
endmodule : smc_regs_asserts
bind smc_regs smc_regs_asserts u_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .flash_hold_pin(flash_hold_pin),
  .ram_size_select(ram_size_select),
  .read_cycle_count(read_cycle_count),
  .write_unlocked(write_unlocked)
);

// *** test/tb.sv ***
// self-checking bench for the misc system control register bank
// assumes smc_regs answering each avalon-mm request one cycle later
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic flash_hold_pin = 1'b0;
  logic flash_rd_req = 1'b0;
  logic flash_rd_done;
  logic [2:0] ram_size_select;
  logic [1:0] read_cycle_count;
  logic write_unlocked;
  int n_mismatch = 0;
  int checks = 0;
  // 25 mhz system clock
  always #20 sys_clk = ~sys_clk;
  smc_regs u_dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_hold_pin(flash_hold_pin), .flash_rd_req(flash_rd_req),
    .flash_rd_done(flash_rd_done), .ram_size_select(ram_size_select),
    .read_cycle_count(read_cycle_count), .write_unlocked(write_unlocked)
  );
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // write held until waitrequest low stands into an edge; lands there
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= 1'b1;
    @(negedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(negedge sys_clk);
    @(posedge sys_clk); // completing edge
    avs_write <= 1'b0;
  endtask : wr
  // read; data taken as it stands into the completing edge
  task rc(input logic [3:0] a, input logic [15:0] e);
    logic [31:0] seen;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(negedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(negedge sys_clk);
    seen = avs_readdata;
    @(posedge sys_clk); // completing edge
    avs_read <= 1'b0;
    chk(seen[31:16], 16'h0);
    chk(seen[15:0], e);
  endtask : rc
  // one flash read access; n is the expected access length in cycles
  task fl(input logic [15:0] n);
    logic [15:0] k;
    k = 16'h0001;
    @(posedge sys_clk);
    flash_rd_req <= 1'b1;
    @(posedge sys_clk);
    flash_rd_req <= 1'b0;
    @(negedge sys_clk);
    while (flash_rd_done !== 1'b1 && k < 16'h0008) begin
      k = k + 16'h0001;
      @(negedge sys_clk);
    end
    chk(k, n);
    @(negedge sys_clk);
    chk(16'(flash_rd_done), 16'h0000);
  endtask : fl
  task complete_run;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // watchdog, far beyond the few hundred cycles of the tests
  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end
  // test sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rc(4'h0, 16'h0000);
    rc(4'h4, 16'h0033);
    rc(4'h8, 16'h0081);
    $display("test reset values done");
    wr(4'h4, 16'h0000);
    wr(4'h8, 16'h0000);
    wr(4'h0, 16'h0095);
    wr(4'h4, 16'h0001);
    rc(4'h0, 16'h0095);
    rc(4'h4, 16'h0033);
    rc(4'h8, 16'h0081);
    $display("test locked writes done");
    wr(4'h0, 16'h0096);
    for (int i = 0; i < 8; i++) begin
      wr(4'h4, 16'hfff8 | 16'(i));
      rc(4'h4, 16'h0130 | 16'(i));
      chk(16'(ram_size_select), 16'(i));
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'h8, 16'hfffc | 16'(i));
      rc(4'h8, 16'h0080 | 16'(i));
      chk(16'(read_cycle_count), 16'(i));
      fl(16'(i + 1));
    end
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'h0002);
    rc(4'h4, 16'h0030);
    $display("test unlocked sweep done");
    flash_hold_pin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rc(4'h8, 16'h0003);
    flash_hold_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rc(4'h8, 16'h0083);
    wr(4'hc, 16'hffff);
    rc(4'hc, 16'h0000);
    $display("test flash ready and unmapped done");
    // reset in mid-run brings back the locked reset state
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rc(4'h4, 16'h0033);
    rc(4'h8, 16'h0081);
    chk(16'(write_unlocked), 16'h0000);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule : tb
